// ===== core/lmt_map.svh
// register offsets, field positions, reset values and timing counts
`ifndef LMT_MAP_SVH
`define LMT_MAP_SVH
// register byte offsets
`define LMT_CTRL_OFS 8'h00
`define LMT_CMD_OFS 8'h04
`define LMT_STAT_OFS 8'h08
`define LMT_MASK_OFS 8'h0C
`define LMT_LIVE_OFS 8'h10
`define LMT_CHAIN_OFS 8'h14
// control field positions
`define LMT_OT_POL_BIT 0
`define LMT_HOME_POL_BIT 1
`define LMT_AUX_POL_BIT 2
`define LMT_OT_ACT_LSB 3
`define LMT_AUX_ACT_LSB 5
`define LMT_AUX_HOME_BIT 7
`define LMT_TIM_QUAL_BIT 8
`define LMT_CTRL_W 9
// command field
`define LMT_CMD_CLR_BIT 0
// event bit count
`define LMT_EV_W 6
// reset values
`define LMT_CTRL_RST 9'h000
`define LMT_MASK_RST 6'h00
`define LMT_CHAIN_RST 6'h00
// chain size limit
`define LMT_CHAIN_MAX 6'h24
// glitch filter, least time rounded up
`define LMT_CLK_NS 4
`define LMT_FILT_NS 1000
`define LMT_FILT_CYC ((`LMT_FILT_NS + `LMT_CLK_NS - 1) / `LMT_CLK_NS)
`endif

// ===== core/lmt_pkg.sv
// types shared by the limit sensor logic
package lmt_pkg;
  // motion mode reported by the motion core
  typedef enum logic [1:0] {
    LMT_OP_IDLE = 2'h0,
    LMT_OP_CONT = 2'h1,
    LMT_OP_POSN = 2'h2,
    LMT_OP_HOME = 2'h3
  } lmt_op_t;
  // protection state, one-hot
  typedef enum logic [1:0] {
    LMT_ST_NORMAL = 2'h1,
    LMT_ST_TRIPPED = 2'h2
  } lmt_prot_t;
endpackage : lmt_pkg

// ===== core/lmt_in_filter.sv
// two-flop synchroniser and stability filter per sensor input
`timescale 1ns/1ps
module lmt_in_filter #(
  parameter int W = 5,
  parameter int CNT = 250
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // raw and filtered levels
  input wire logic [W-1:0] raw_in,
  output logic [W-1:0] filt_out
);
  localparam int CW = $clog2(CNT + 1);
  localparam logic [CW-1:0] LAST = CW'(CNT - 1);
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      logic s1_ff; // first stage, read only by s2_ff
      logic s2_ff;
      logic [CW-1:0] cnt_ff; // cycles the new level has held
      // synchroniser
      always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
          s1_ff <= 1'b0;
          s2_ff <= 1'b0;
        end else begin
          s1_ff <= raw_in[i];
          s2_ff <= s1_ff;
        end
      end
      // level accepted only after it held for the full count
      always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
          cnt_ff <= '0;
          filt_out[i] <= 1'b0;
        end else if (s2_ff == filt_out[i]) begin
          cnt_ff <= '0;
        end else if (cnt_ff == LAST) begin
          cnt_ff <= '0;
          filt_out[i] <= s2_ff;
        end else begin
          cnt_ff <= cnt_ff + CW'(1);
        end
      end
    end
  endgenerate
endmodule : lmt_in_filter

// ===== core/lmt_quad_mon.sv
// quadrature position monitor pulses from step and direction
`timescale 1ns/1ps
module lmt_quad_mon (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // motor steps
  input wire logic step_pulse_in,
  input wire logic step_dir_in,
  // line-driver pairs
  output logic phase_a_out,
  output logic phase_a_n_out,
  output logic phase_b_out,
  output logic phase_b_n_out
);
  logic [1:0] pos_ff; // two-bit position count
  logic [1:0] nxt_pos;
  // one count per step, direction picks the sign
  always_comb begin
    nxt_pos = pos_ff;
    if (step_pulse_in) begin
      nxt_pos = step_dir_in ? pos_ff + 2'h1 : pos_ff - 2'h1;
    end
  end
  // outputs registered so the pairs never skew
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pos_ff <= 2'h0;
      phase_a_out <= 1'b0;
      phase_a_n_out <= 1'b1;
      phase_b_out <= 1'b0;
      phase_b_n_out <= 1'b1;
    end else begin
      pos_ff <= nxt_pos;
      phase_a_out <= nxt_pos[1];
      phase_a_n_out <= ~nxt_pos[1];
      phase_b_out <= nxt_pos[1] ^ nxt_pos[0];
      phase_b_n_out <= ~(nxt_pos[1] ^ nxt_pos[0]);
    end
  end
endmodule : lmt_quad_mon

// ===== core/lmt_sensor_top.sv
// limit, home and auxiliary sensor handling with APB registers
`timescale 1ns/1ps
`include "lmt_map.svh"
// Operation
// - one shared polarity for both overtravel limits
// - limit in motion raises alarm and stops
// - limit stop uses overtravel stop action
// - clear input pulse or command cancels alarm
// - homing limit reverses motor, no alarm
// - three-sensor homing takes home switch
// - home switch has its own polarity
// - auxiliary sensor has its own polarity
// - homing auxiliary sensor qualified by timing signal
// - auxiliary sensor forces stop in continuous
// - homing auxiliary sensor never forces stop
// - daisy chain holds at most 36 drivers
// - phase A and B monitor outputs
// - alarm output on when normal
// - active means coupler carries current
module lmt_sensor_top
  import lmt_pkg::*;
#(
  parameter int FILT_CYC = `LMT_FILT_CYC
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // sensors, high while the coupler carries current
  input wire logic pos_overtravel_in,
  input wire logic neg_overtravel_in,
  input wire logic home_switch_in,
  input wire logic aux_sensor_in,
  input wire logic alarm_clear_in,
  // motion core
  input wire lmt_op_t op_mode_in,
  input wire logic home_3sensor_in,
  input wire logic timing_in,
  input wire logic step_pulse_in,
  input wire logic step_dir_in,
  // protection and homing
  output logic alarm_out,
  output logic stop_req_out,
  output logic [1:0] stop_action_out,
  output logic reverse_req_out,
  output logic seek_dir_pos_out,
  output logic home_found_out,
  // position monitor
  output logic phase_a_monitor_out,
  output logic phase_a_monitor_n_out,
  output logic phase_b_monitor_out,
  output logic phase_b_monitor_n_out,
  // interrupt
  output logic irq_out
);
  // reset release through two flops
  logic rst_meta_ff;
  logic rst_sync_n;
  // assertions below share the core clock and the released reset
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_sync_n);
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_ff <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_sync_n <= rst_meta_ff;
    end
  end

  // address decode used only by the pslverr response
  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a == `LMT_CTRL_OFS) || (a == `LMT_CMD_OFS) ||
      (a == `LMT_STAT_OFS) || (a == `LMT_MASK_OFS) ||
      (a == `LMT_LIVE_OFS) || (a == `LMT_CHAIN_OFS);
  endfunction : is_mapped

  // register state
  logic [`LMT_CTRL_W-1:0] ctrl_ff; // polarities, stop actions, homing use
  logic [`LMT_EV_W-1:0] stat_ff; // sticky events
  logic [`LMT_EV_W-1:0] mask_ff; // interrupt enables
  logic [5:0] chain_ff; // this driver's place in the chain
  logic [31:0] rd_ff; // read data captured in the setup cycle

  // control fields
  logic ot_pol;
  logic home_pol;
  logic aux_pol;
  logic [1:0] ot_act;
  logic [1:0] aux_act_cfg;
  logic aux_home_use;
  logic tim_qual;
  assign ot_pol = ctrl_ff[`LMT_OT_POL_BIT];
  assign home_pol = ctrl_ff[`LMT_HOME_POL_BIT];
  assign aux_pol = ctrl_ff[`LMT_AUX_POL_BIT];
  assign ot_act = ctrl_ff[`LMT_OT_ACT_LSB +: 2];
  assign aux_act_cfg = ctrl_ff[`LMT_AUX_ACT_LSB +: 2];
  assign aux_home_use = ctrl_ff[`LMT_AUX_HOME_BIT];
  assign tim_qual = ctrl_ff[`LMT_TIM_QUAL_BIT];

  // bus phases
  logic setup_ph;
  logic wr_acc;
  logic rd_acc;
  assign setup_ph = psel && !penable;
  assign wr_acc = psel && penable && pwrite;
  assign rd_acc = psel && penable && !pwrite;
  // read data is ready by the access phase, so no wait states
  assign pready = 1'b1;
  assign pslverr = psel && penable && !is_mapped(paddr);
  assign prdata = rd_ff;

  // filtered sensor levels
  logic [4:0] filt;
  lmt_in_filter #(.W(5), .CNT(FILT_CYC)) u_filt (
    .core_clk(core_clk),
    .rst_n(rst_sync_n),
    .raw_in({alarm_clear_in, aux_sensor_in, home_switch_in,
      neg_overtravel_in, pos_overtravel_in}),
    .filt_out(filt)
  );

  // polarity: clear means normally open, active on current
  logic pos_act;
  logic neg_act;
  logic home_act;
  logic aux_act;
  logic aux_home_q;
  assign pos_act = filt[0] ^ ot_pol;
  assign neg_act = filt[1] ^ ot_pol;
  assign home_act = filt[2] ^ home_pol;
  assign aux_act = filt[3] ^ aux_pol;
  // timing signal gates the slot for a sharper home point
  assign aux_home_q = aux_act && (!tim_qual || timing_in);

  // previous levels for edge detection
  logic [5:0] prev_ff;
  always_ff @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      prev_ff <= 6'h00;
    end else begin
      prev_ff <= {aux_home_q, filt[4], aux_act, home_act, neg_act, pos_act};
    end
  end
  logic pos_rise;
  logic neg_rise;
  logic home_rise;
  logic aux_rise;
  logic acl_rise;
  logic auxq_rise;
  assign pos_rise = pos_act && !prev_ff[0];
  assign neg_rise = neg_act && !prev_ff[1];
  assign home_rise = home_act && !prev_ff[2];
  assign aux_rise = aux_act && !prev_ff[3];
  assign acl_rise = filt[4] && !prev_ff[4];
  assign auxq_rise = aux_home_q && !prev_ff[5];

  // event decode
  lmt_prot_t prot_ff;
  logic moving;
  logic seeking;
  logic trip;
  logic clr;
  logic aux_stop;
  logic rev;
  logic found;
  assign moving = (op_mode_in == LMT_OP_CONT) || (op_mode_in == LMT_OP_POSN);
  assign seeking = (op_mode_in == LMT_OP_HOME);
  // edge, not level: after a clear the motor may back off the switch
  assign trip = moving && (pos_rise || neg_rise) &&
    (prot_ff == LMT_ST_NORMAL);
  assign clr = acl_rise ||
    (wr_acc && paddr == `LMT_CMD_OFS && pwdata[`LMT_CMD_CLR_BIT]);
  assign aux_stop = (op_mode_in == LMT_OP_CONT) && aux_rise && !aux_home_use &&
    (prot_ff == LMT_ST_NORMAL);
  assign rev = seeking && (pos_rise || neg_rise);
  assign found = seeking && ((home_3sensor_in && home_rise) ||
    (aux_home_use && auxq_rise));

  // protection state: trip only from normal, clear returns
  always_ff @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      prot_ff <= LMT_ST_NORMAL;
    end else begin
      unique case (prot_ff)
        LMT_ST_NORMAL: begin
          if (trip) begin
            prot_ff <= LMT_ST_TRIPPED;
          end
        end
        LMT_ST_TRIPPED: begin
          if (clr) begin
            prot_ff <= LMT_ST_NORMAL;
          end
        end
        default: begin
          prot_ff <= LMT_ST_TRIPPED; // corrupt code fails safe
        end
      endcase
    end
  end

  // alarm output, on while normal
  always_ff @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      alarm_out <= 1'b1;
    end else if (trip) begin
      alarm_out <= 1'b0;
    end else if (clr) begin
      alarm_out <= 1'b1;
    end
  end

  // stop request pulse with its method; limit wins over sensor
  always_ff @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      stop_req_out <= 1'b0;
      stop_action_out <= 2'h0;
    end else begin
      stop_req_out <= trip || aux_stop;
      if (trip) begin
        stop_action_out <= ot_act;
      end else if (aux_stop) begin
        stop_action_out <= aux_act_cfg;
      end
    end
  end

  // homing: reverse away from whichever limit was hit
  always_ff @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      reverse_req_out <= 1'b0;
      seek_dir_pos_out <= 1'b1;
      home_found_out <= 1'b0;
    end else begin
      reverse_req_out <= rev;
      home_found_out <= found;
      if (rev && pos_rise && !neg_rise) begin
        seek_dir_pos_out <= 1'b0;
      end else if (rev && neg_rise && !pos_rise) begin
        seek_dir_pos_out <= 1'b1;
      end
    end
  end

  // control, mask and chain registers
  always_ff @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      ctrl_ff <= `LMT_CTRL_RST;
      mask_ff <= `LMT_MASK_RST;
      chain_ff <= `LMT_CHAIN_RST;
    end else if (wr_acc) begin
      if (paddr == `LMT_CTRL_OFS) begin
        ctrl_ff <= pwdata[`LMT_CTRL_W-1:0];
      end
      if (paddr == `LMT_MASK_OFS) begin
        mask_ff <= pwdata[`LMT_EV_W-1:0];
      end
      // places beyond the chain limit are ignored
      if (paddr == `LMT_CHAIN_OFS && pwdata[5:0] < `LMT_CHAIN_MAX) begin
        chain_ff <= pwdata[5:0];
      end
    end
  end

  // sticky events; only bits already read are cleared, set wins
  logic [`LMT_EV_W-1:0] ev;
  logic [`LMT_EV_W-1:0] stat_clr;
  assign ev = {clr && prot_ff == LMT_ST_TRIPPED, found, rev, aux_stop,
    trip && neg_rise, trip && pos_rise};
  assign stat_clr = (rd_acc && paddr == `LMT_STAT_OFS) ?
    rd_ff[`LMT_EV_W-1:0] : '0;
  always_ff @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      stat_ff <= '0;
    end else begin
      stat_ff <= (stat_ff & ~stat_clr) | ev;
    end
  end

  // interrupt level from unmasked events
  always_ff @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= |(((stat_ff & ~stat_clr) | ev) & mask_ff);
    end
  end

  // read data captured in setup, unmapped reads zero
  always_ff @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      rd_ff <= 32'h0;
    end else if (setup_ph && !pwrite) begin
      unique case (paddr)
        `LMT_CTRL_OFS: rd_ff <= {23'h0, ctrl_ff};
        `LMT_STAT_OFS: rd_ff <= {26'h0, stat_ff};
        `LMT_MASK_OFS: rd_ff <= {26'h0, mask_ff};
        `LMT_LIVE_OFS: rd_ff <= {26'h0, seek_dir_pos_out,
          prot_ff == LMT_ST_TRIPPED, aux_act, home_act, neg_act, pos_act};
        `LMT_CHAIN_OFS: rd_ff <= {26'h0, chain_ff};
        default: rd_ff <= 32'h0;
      endcase
    end
  end

  // position monitor pulses
  lmt_quad_mon u_quad (
    .core_clk(core_clk),
    .rst_n(rst_sync_n),
    .step_pulse_in(step_pulse_in),
    .step_dir_in(step_dir_in),
    .phase_a_out(phase_a_monitor_out),
    .phase_a_n_out(phase_a_monitor_n_out),
    .phase_b_out(phase_b_monitor_out),
    .phase_b_n_out(phase_b_monitor_n_out)
  );

  // checks
  // a clear right after the trip may legally raise the alarm line again
  chk_trip_alarm: assert property (trip |=> !alarm_out ##1
    (!alarm_out || $past(clr)))
    else $error("limit trip did not drop alarm");
  chk_trip_stop: assert property (trip |=> stop_req_out &&
    stop_action_out == $past(ot_act))
    else $error("limit trip stop wrong");
  chk_clear_alarm: assert property ((prot_ff == LMT_ST_TRIPPED && clr)
    |=> alarm_out)
    else $error("alarm not cleared");
  chk_home_noalarm: assert property ((seeking && alarm_out) |=> alarm_out)
    else $error("alarm raised while homing");
  chk_home_reverse: assert property ((seeking && pos_rise && !neg_rise)
    |=> reverse_req_out && !seek_dir_pos_out)
    else $error("no reverse off positive limit");
  chk_home_found: assert property ((seeking && home_3sensor_in && home_rise)
    |=> home_found_out)
    else $error("home switch not taken");
  chk_aux_stop: assert property (($rose(aux_act) && op_mode_in == LMT_OP_CONT &&
    !aux_home_use && alarm_out && !trip) |=> stop_req_out &&
    stop_action_out == $past(aux_act_cfg))
    else $error("sensor stop missing");
  chk_aux_excl: assert property ((aux_home_use && !trip) |=> !stop_req_out)
    else $error("homing sensor forced a stop");
  chk_chain_max: assert property (chain_ff < `LMT_CHAIN_MAX)
    else $error("chain place out of range");
  chk_alarm_state: assert property (##1 alarm_out ==
    (prot_ff == LMT_ST_NORMAL))
    else $error("alarm output and state disagree");
endmodule : lmt_sensor_top

// ===== tb/lmt_sensor_model.sv
// sensor contacts as seen through the input couplers
`timescale 1ns/1ps
module lmt_sensor_model (
  // clock
  input wire logic core_clk,
  // contact actuation and contact type, one bit per input
  input wire logic [4:0] act,
  input wire logic [4:0] nc,
  // coupler current per input
  output logic [4:0] lvl
);
  // coupler current, starts with every coupler dark
  logic [4:0] cur_ff = 5'h00;
  // a normally closed contact carries current until actuated
  always @(posedge core_clk) begin
    cur_ff <= act ^ nc;
  end
  assign lvl = cur_ff;
endmodule : lmt_sensor_model

// ===== tb/lmt_sensor_top_tb.sv
// self-checking bench for the limit sensor logic
`timescale 1ns/1ps
`include "lmt_map.svh"
module lmt_sensor_top_tb;
  import lmt_pkg::*;
  localparam int FC = 3; // short filter keeps the run brief
  localparam int SETL = FC + 8; // time for a level to pass the filter
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr;
  logic [4:0] act = 5'h00, nc = 5'h00, lvl; // pos, neg, home, aux, clear
  lmt_op_t op_mode = LMT_OP_IDLE;
  logic home3 = 1'b0, timing = 1'b0, step = 1'b0, sdir = 1'b0;
  logic alarm, stop_req, rev, seek, found, pa, pan, pb, pbn, irq;
  logic [1:0] stop_act;
  logic [35:0] expq[$]; // kind and value of each awaited result
  logic [31:0] rv;
  logic [1:0] cnt;
  int bad_count = 0;
  int checks_done = 0;
  // free running clock
  always #2 core_clk = ~core_clk;
  lmt_sensor_model sens (.core_clk(core_clk), .act(act), .nc(nc), .lvl(lvl));
  lmt_sensor_top #(.FILT_CYC(FC)) dut (.core_clk(core_clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pos_overtravel_in(lvl[0]),
    .neg_overtravel_in(lvl[1]), .home_switch_in(lvl[2]), .aux_sensor_in(lvl[3]),
    .alarm_clear_in(lvl[4]), .op_mode_in(op_mode), .home_3sensor_in(home3),
    .timing_in(timing), .step_pulse_in(step), .step_dir_in(sdir), .alarm_out(alarm),
    .stop_req_out(stop_req), .stop_action_out(stop_act), .reverse_req_out(rev),
    .seek_dir_pos_out(seek), .home_found_out(found), .phase_a_monitor_out(pa),
    .phase_a_monitor_n_out(pan), .phase_b_monitor_out(pb), .phase_b_monitor_n_out(pbn),
    .irq_out(irq));
  // single comparison point
  task check(input string nm, input logic [35:0] seen, input logic [35:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  // a result showed up: match it against the oldest note
  task note(input logic [2:0] k, input logic [32:0] v);
    if (expq.size() == 0) check("unasked result", {k, v}, 36'h0);
    else check("result", {k, v}, expq.pop_front());
  endtask : note
  // watcher: reads, stop, reverse and home pulses in arrival order
  always @(posedge core_clk) begin
    if (rst_n) begin
      if (psel && penable && pready && !pwrite) note(3'h1, {pslverr, prdata});
      if (stop_req) note(3'h2, {30'h0, alarm, stop_act});
      if (rev) note(3'h3, {32'h0, alarm});
      if (found) note(3'h4, 33'h0);
    end
  end
  // let edge updates land before looking
  task tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : tick
  // one apb transfer, held until pready is seen high
  task xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    // only the watchdog ends a wait that never sees pready
    do begin
      @(posedge core_clk);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
  task rd(input logic [7:0] a, input logic [32:0] exp);
    expq.push_back({3'h1, exp});
    xfer(1'b0, a, 32'h0);
  endtask : rd
  // move the contacts and wait past the filter
  task sense(input logic [4:0] a);
    @(posedge core_clk);
    act <= a;
    tick(SETL);
  endtask : sense
  // every awaited result must arrive within a bounded time
  task wait_drain;
    int n;
    n = 0;
    while (expq.size() != 0 && n < 200) begin
      tick(1);
      n++;
    end
    check("pending results", 36'(expq.size()), 36'h0);
    expq.delete();
  endtask : wait_drain
  task stop_test;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : stop_test
  // watchdog against a hang
  initial begin
    repeat (20000) @(posedge core_clk);
    bad_count++;
    stop_test();
  end
  // main sequence
  initial begin
    void'($urandom(26));
    repeat (20) @(posedge core_clk);
    rst_n <= 1'b1;
    tick(3);
    check("alarm at reset", 36'(alarm), 36'h1);
    rd(`LMT_CTRL_OFS, 33'h0);
    rd(`LMT_MASK_OFS, 33'h0);
    rd(8'h18, {1'b1, 32'h0});
    xfer(1'b1, `LMT_CHAIN_OFS, 32'd35);
    xfer(1'b1, `LMT_CHAIN_OFS, 32'd36);
    rd(`LMT_CHAIN_OFS, 33'd35);
    // random polarity and contact states, shared limit polarity
    for (int i = 0; i < 4; i++) begin
      rv = $urandom;
      xfer(1'b1, `LMT_CTRL_OFS, {29'h0, rv[2:0]});
      nc <= {1'b0, rv[2], rv[1], rv[0], rv[0]};
      sense({1'b0, rv[7:4]});
      rd(`LMT_LIVE_OFS, {27'h0, 2'b10, rv[7:4]});
    end
    nc <= 5'h00;
    sense(5'h00);
    xfer(1'b1, `LMT_MASK_OFS, 32'h3F);
    // hard limit trip with every stop action, both clear paths
    for (int i = 0; i < 4; i++) begin
      op_mode <= (i % 2 == 1) ? LMT_OP_POSN : LMT_OP_CONT;
      xfer(1'b1, `LMT_CTRL_OFS, 32'(i) << `LMT_OT_ACT_LSB);
      expq.push_back({3'h2, 30'h0, 1'b0, 2'(i)});
      sense((i % 2 == 1) ? 5'h02 : 5'h01);
      wait_drain();
      tick(2);
      check("irq on trip", 36'(irq), 36'h1);
      rd(`LMT_STAT_OFS, (i % 2 == 1) ? 33'h2 : 33'h1);
      tick(2);
      check("irq after read", 36'(irq), 36'h0);
      if (i >= 2) xfer(1'b1, `LMT_CMD_OFS, 32'h1);
      else begin
        sense(act | 5'h10);
        sense(act & 5'h0F);
      end
      tick(3);
      check("alarm after clear", 36'(alarm), 36'h1);
      rd(`LMT_STAT_OFS, 33'h20);
      sense(5'h00);
    end
    // homing reverses on either limit without alarm
    @(posedge core_clk);
    op_mode <= LMT_OP_HOME;
    expq.push_back({3'h3, 33'h1});
    sense(5'h01);
    wait_drain();
    check("seek after pos", 36'({alarm, seek}), 36'h2);
    expq.push_back({3'h3, 33'h1});
    sense(5'h02);
    wait_drain();
    check("seek after neg", 36'({alarm, seek}), 36'h3);
    sense(5'h00);
    @(posedge core_clk);
    home3 <= 1'b1;
    expq.push_back({3'h4, 33'h0});
    sense(5'h04);
    wait_drain();
    sense(5'h00);
    @(posedge core_clk);
    home3 <= 1'b0;
    // auxiliary sensor for homing, qualified by the timing signal
    xfer(1'b1, `LMT_CTRL_OFS, 32'h180);
    // slot seen while the timing signal is low must not mark home
    sense(5'h08);
    wait_drain();
    @(posedge core_clk);
    expq.push_back({3'h4, 33'h0});
    timing <= 1'b1;
    tick(2);
    wait_drain();
    sense(5'h00);
    @(posedge core_clk);
    op_mode <= LMT_OP_CONT;
    sense(5'h08);
    sense(5'h00);
    wait_drain();
    // auxiliary forced stop in continuous motion
    rv = $urandom;
    xfer(1'b1, `LMT_CTRL_OFS, {30'h0, rv[1:0]} << `LMT_AUX_ACT_LSB);
    expq.push_back({3'h2, 30'h0, 1'b1, rv[1:0]});
    sense(5'h08);
    wait_drain();
    sense(5'h00);
    // a one-cycle glitch must not pass the filter
    @(posedge core_clk);
    act <= 5'h01;
    @(posedge core_clk);
    act <= 5'h00;
    tick(SETL);
    wait_drain();
    check("alarm after glitch", 36'(alarm), 36'h1);
    // quadrature monitor follows random steps
    cnt = 2'h0;
    for (int i = 0; i < 10; i++) begin
      rv = $urandom;
      @(posedge core_clk);
      step <= 1'b1;
      sdir <= rv[0];
      @(posedge core_clk);
      step <= 1'b0;
      cnt = rv[0] ? cnt + 2'h1 : cnt - 2'h1;
      tick(2);
      check("phases", 36'({pa, pan, pb, pbn}),
        36'({cnt[1], ~cnt[1], cnt[1] ^ cnt[0], ~(cnt[1] ^ cnt[0])}));
    end
    wait_drain();
    stop_test();
  end
endmodule : lmt_sensor_top_tb
